// ---- logic/pwr_mgr_pkg.sv ----
// Shared constants for the USB device power manager and its CPU-side peer.
// Assumes both ends run on mclk at 50 MHz with rst_n asynchronous, active low.
package pwr_mgr_pkg;
    localparam int unsigned CLK_MHZ          = 50;
    // Command codes carried on the command strobe
    localparam logic [7:0]  CMD_SLEEP        = 8'h01;
    localparam logic [7:0]  CMD_CLASS_RUN    = 8'h10;
    localparam logic [7:0]  CMD_SEND_REPORT  = 8'h22;
    localparam logic [7:0]  RUN_STOP         = 8'h00;
    localparam logic [7:0]  RUN_START        = 8'h01;
    // Event status bit positions
    localparam int unsigned EV_SUSPEND_BIT   = 0;
    localparam int unsigned EV_ATTACH_BIT    = 1;
    localparam int unsigned EV_RESUME_BIT    = 2;
    localparam int unsigned EV_ERROR_BIT     = 3;
    localparam logic [7:0]  EV_NONE          = 8'h00;
    // Width of the wake pulse the CPU drives, in cycles
    localparam int unsigned WAKE_PULSE_CYC   = 4;
    // CPU timing limits after a notification
    localparam int unsigned SLEEP_LIMIT_US   = 8000;
    localparam int unsigned SLEEP_LIMIT_CYC  = SLEEP_LIMIT_US * CLK_MHZ;
    localparam int unsigned WAKE_LIMIT_US    = 5000;
    localparam int unsigned WAKE_LIMIT_CYC   = WAKE_LIMIT_US * CLK_MHZ;
endpackage

// ---- logic/pwr_link_if.sv ----
// Link between the power manager (dev) and the main CPU side (cpu).
// Assumes one clock shared by both ends; no clocking block.
`timescale 1ns/10ps
interface pwr_link_if;
    logic       cmd_valid;        // One-cycle command strobe
    logic [7:0] cmd_code;
    logic [7:0] cmd_arg;
    logic       data_write;       // One-cycle report data write
    logic       wake_req;         // Wake request pin level
    logic       serial_ready_pin; // High while ACTIVE
    logic       event_irq_n;      // Event pin, low while events pend
    logic [7:0] event_status;     // Sticky event bits
    logic       event_ack;        // One-cycle clear of event_status
    logic       error_flag;       // Write was discarded

    modport dev (
        input  cmd_valid, cmd_code, cmd_arg, data_write, wake_req, event_ack,
        output serial_ready_pin, event_irq_n, event_status, error_flag
    );
    modport cpu (
        output cmd_valid, cmd_code, cmd_arg, data_write, wake_req, event_ack,
        input  serial_ready_pin, event_irq_n, event_status, error_flag
    );
endinterface

// ---- logic/usb_device_power_manager.sv ----
// Power-state controller for a serial-to-USB HID device bridge.
// Assumes USB bus events arrive as clean one-cycle pulses on mclk;
// the wake pin comes from another chip and is synchronised here.
`timescale 1ns/10ps

module usb_device_power_manager
    import pwr_mgr_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst_n,
    pwr_link_if.dev   link,
    input  wire logic usb_attach,        // Host present level
    input  wire logic usb_suspend,       // Suspend detected pulse
    input  wire logic usb_resume,        // Resume detected pulse
    input  wire logic usb_bus_reset,     // Bus reset pulse
    input  wire logic usb_rwake_enable,  // Host permits remote wakeup
    output logic      usb_remote_wakeup, // Remote wakeup signalling request
    output logic      usb_tx_report,     // Pending report sent pulse
    output logic      usb_connect,       // Pull-up / connection enable
    output logic      chip_sleep,        // Low-power state flag
    output logic      usb_suspended      // USB status Suspend
);
    typedef enum logic [1:0] {ST_ACTIVE, ST_SLEEP} pwr_state_t;

    pwr_state_t state_reg;
    logic [2:0] wake_sync_reg;
    logic       wake_seen_reg;
    logic       detach_pend_reg;
    logic       run_start_reg;
    logic       rwake_pend_reg;
    logic       reconnect_reg;
    logic       attach_d_reg;
    logic [7:0] ev_reg;
    logic [7:0] ev_set;
    logic       cmd_ok;
    logic       wake_rise;
    logic       detach;

    // Three stages; a change counts once stages two and three agree
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            wake_sync_reg <= 3'b000;
        else
            wake_sync_reg <= {wake_sync_reg[1:0], link.wake_req};
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            wake_seen_reg <= 1'b0;
        else if (wake_sync_reg[2] == wake_sync_reg[1])
            wake_seen_reg <= wake_sync_reg[2];
    end
    assign wake_rise = wake_sync_reg[2] & wake_sync_reg[1] & ~wake_seen_reg;

    assign cmd_ok = link.cmd_valid && (state_reg == ST_ACTIVE);
    assign detach = attach_d_reg & ~usb_attach;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            attach_d_reg <= 1'b0;
        else
            attach_d_reg <= usb_attach;
    end

    // Class run setting
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            run_start_reg <= 1'b0;
        else if (cmd_ok && link.cmd_code == CMD_CLASS_RUN)
            run_start_reg <= (link.cmd_arg == RUN_START);
    end

    // Power state
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            state_reg <= ST_ACTIVE;
        else if (state_reg == ST_ACTIVE && cmd_ok && link.cmd_code == CMD_SLEEP)
            state_reg <= ST_SLEEP;
        else if (state_reg == ST_SLEEP && wake_rise)
            state_reg <= ST_ACTIVE;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            usb_suspended <= 1'b0;
        else if (usb_resume || usb_bus_reset || detach)
            usb_suspended <= 1'b0;
        else if (usb_suspend && usb_attach)
            usb_suspended <= 1'b1;
    end

    // Detach seen while asleep, handled after waking
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            detach_pend_reg <= 1'b0;
        else if (detach && state_reg == ST_SLEEP)
            detach_pend_reg <= 1'b1;
        else if (state_reg == ST_ACTIVE)
            detach_pend_reg <= 1'b0;
    end

    // report command while suspended and permitted
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            rwake_pend_reg <= 1'b0;
        else if (usb_resume || usb_bus_reset || detach)
            rwake_pend_reg <= 1'b0;
        else if (cmd_ok && link.cmd_code == CMD_SEND_REPORT && usb_suspended
                 && usb_rwake_enable)
            rwake_pend_reg <= 1'b1;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            reconnect_reg <= 1'b0;
        else
            reconnect_reg <= usb_bus_reset && usb_suspended;
    end

    // Connection gated by class run; start forbids attached sleep use (CMD_SLEEP is still taken at any run setting and attach level)
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            usb_connect <= 1'b0;
        else
            usb_connect <= run_start_reg && !reconnect_reg
                           && !(usb_bus_reset && usb_suspended);
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            usb_remote_wakeup <= 1'b0;
            usb_tx_report     <= 1'b0;
        end
        else
        begin
            usb_remote_wakeup <= rwake_pend_reg && usb_suspended;
            usb_tx_report     <= rwake_pend_reg && usb_resume;
        end
    end

    // Events to raise this cycle
    always_comb
    begin
        ev_set = EV_NONE;
        ev_set[EV_SUSPEND_BIT] = usb_suspend && usb_attach;
        ev_set[EV_RESUME_BIT]  = usb_resume && usb_suspended;
        ev_set[EV_ATTACH_BIT]  = (detach && state_reg == ST_ACTIVE)
                                 || (detach_pend_reg && state_reg == ST_ACTIVE);
        ev_set[EV_ERROR_BIT]   = link.data_write && usb_suspended
                                 && !usb_rwake_enable && state_reg == ST_ACTIVE;
    end

    // Sticky events; a set in the clearing cycle wins
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            ev_reg <= EV_NONE;
        else if (link.event_ack)
            ev_reg <= ev_set;
        else
            ev_reg <= ev_reg | ev_set;
    end

    // Pin drivers registered
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            link.event_irq_n      <= 1'b1;
            link.serial_ready_pin <= 1'b1;
            link.error_flag       <= 1'b0;
            chip_sleep            <= 1'b0;
        end
        else
        begin
            // asleep: detach or resume pulls pin low
            link.event_irq_n      <= !((ev_reg != EV_NONE)
                                       || (state_reg == ST_SLEEP
                                           && (detach_pend_reg || usb_resume)));
            link.serial_ready_pin <= (state_reg == ST_ACTIVE);
            link.error_flag       <= ev_reg[EV_ERROR_BIT];
            chip_sleep            <= (state_reg == ST_SLEEP);
        end
    end
    assign link.event_status = ev_reg;
endmodule

// ---- logic/cpu_power_client.sv ----
// CPU-side end of the power link: issues commands and wake pulses.
// Assumes the power manager shares mclk; its pins need no synchroniser.
`timescale 1ns/10ps
module cpu_power_client
    import pwr_mgr_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    pwr_link_if.cpu         link,
    input  wire logic       req_cmd,    // Send a command pulse
    input  wire logic [7:0] req_code,
    input  wire logic [7:0] req_arg,
    input  wire logic       req_write,  // Report data write pulse
    input  wire logic       req_ack,    // Clear events pulse
    output logic            busy        // Wake pulse in progress
);
    logic [3:0] wake_cnt_reg;
    logic       irq_d_reg;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            irq_d_reg <= 1'b1;
        else
            irq_d_reg <= link.event_irq_n;
    end

    // answer a falling event pin in SLEEP with a wake pulse
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            wake_cnt_reg <= 4'h0;
        else if (wake_cnt_reg != 4'h0)
            wake_cnt_reg <= wake_cnt_reg - 4'h1;
        else if (irq_d_reg && !link.event_irq_n && !link.serial_ready_pin)
            wake_cnt_reg <= 4'(WAKE_PULSE_CYC);
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            link.wake_req   <= 1'b0;
            link.cmd_valid  <= 1'b0;
            link.cmd_code   <= 8'h00;
            link.cmd_arg    <= 8'h00;
            link.data_write <= 1'b0;
            link.event_ack  <= 1'b0;
            busy            <= 1'b0;
        end
        else
        begin
            link.wake_req   <= (wake_cnt_reg != 4'h0);
            link.cmd_valid  <= req_cmd && link.serial_ready_pin;
            link.cmd_code   <= req_code;
            link.cmd_arg    <= req_arg;
            link.data_write <= req_write && link.serial_ready_pin;
            link.event_ack  <= req_ack;
            busy            <= (wake_cnt_reg != 4'h0);
        end
    end
endmodule

// ---- tb/pwr_link_checker.sv ----
// Checker for the power link joining the two ends.
// Assumes one clock domain and rst_n asynchronous, active low.
`timescale 1ns/10ps
module pwr_link_checker
    import pwr_mgr_pkg::*;
(
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic       data_write,
    input wire logic       wake_req,
    input wire logic       serial_ready_pin,
    input wire logic       event_irq_n,
    input wire logic [7:0] event_status,
    input wire logic       error_flag
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // Ready pin answers sleep and wake; wake pulse holds at least three cycles
    property p_sleep;
        cmd_valid && cmd_code == CMD_SLEEP && serial_ready_pin |-> ##2 !serial_ready_pin;
    endproperty
    a_sleep: assert property (p_sleep) else $error("ready high after sleep");
    property p_wake;
        $rose(wake_req) && !serial_ready_pin |-> ##[2:8] serial_ready_pin;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_width;
        $rose(wake_req) |-> wake_req[*3];
    endproperty
    a_width: assert property (p_width) else $error("wake pulse short");
    // Client answers the event pin while asleep
    property p_kick;
        $fell(event_irq_n) && !serial_ready_pin |-> ##[1:4] wake_req;
    endproperty
    a_kick: assert property (p_kick) else $error("no wake request");
    // Event pin follows the sticky word
    property p_irq_low;
        (event_status != EV_NONE) |=> !event_irq_n;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("event pin high");
    property p_irq_high;
        event_status == EV_NONE ##1 serial_ready_pin |-> event_irq_n;
    endproperty
    a_irq_high: assert property (p_irq_high) else $error("event pin low");
    // Writes while asleep never raise the error
    property p_wr_sleep;
        !serial_ready_pin && data_write && !error_flag ##1 !serial_ready_pin |-> !error_flag;
    endproperty
    a_wr_sleep: assert property (p_wr_sleep) else $error("write taken asleep");
    property p_err;
        // The flag is registered from the sticky word, so it trails it by one edge
        error_flag == $past(event_status[EV_ERROR_BIT]);
    endproperty
    a_err: assert property (p_err) else $error("error flag apart");
    // Main paths reached
    c_sleep: cover property (cmd_valid && cmd_code == CMD_SLEEP);
    c_kick: cover property ($fell(event_irq_n) && !serial_ready_pin);
    c_err: cover property ($rose(error_flag));
endmodule

// ---- tb/tb_top.sv ----
// Bench joining the power manager and the CPU client over one link.
// Assumes the package, link interface and both ends compile first.
`timescale 1ns/10ps
module tb_top
    import pwr_mgr_pkg::*;
();
    logic       mclk;
    logic       rst_n;
    logic       usb_attach;
    logic       usb_suspend;
    logic       usb_resume;
    logic       usb_bus_reset;
    logic       usb_rwake_enable;
    logic       req_cmd;
    logic       req_write;
    logic       req_ack;
    logic [7:0] req_code;
    logic [7:0] req_arg;
    logic [7:0] prev_ev = 8'h00;
    logic       busy;
    time        t_susp;
    logic       usb_remote_wakeup;
    logic       usb_tx_report;
    logic       usb_connect;
    logic       chip_sleep;
    logic       usb_suspended;
    logic [7:0] ev_q[$];
    int         error_cnt = 0;
    int         total_checks = 0;

    pwr_link_if link();
    usb_device_power_manager i_usb_device_power_manager (.mclk, .rst_n, .link, .usb_attach,
        .usb_suspend, .usb_resume, .usb_bus_reset, .usb_rwake_enable, .usb_remote_wakeup,
        .usb_tx_report, .usb_connect, .chip_sleep, .usb_suspended);
    cpu_power_client i_cpu_power_client (.mclk, .rst_n, .link, .req_cmd, .req_code,
        .req_arg, .req_write, .req_ack, .busy(busy));
    pwr_link_checker i_pwr_link_checker (.mclk, .rst_n, .cmd_valid(link.cmd_valid),
        .cmd_code(link.cmd_code), .data_write(link.data_write), .wake_req(link.wake_req),
        .serial_ready_pin(link.serial_ready_pin), .event_irq_n(link.event_irq_n),
        .event_status(link.event_status), .error_flag(link.error_flag));

    always #10 mclk = ~mclk;

    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    function automatic logic pick(input int k);
        case (k)
            0: return link.serial_ready_pin;
            1: return usb_remote_wakeup;
            2: return usb_tx_report;
            3: return usb_connect;
            default: return busy;
        endcase
    endfunction
    // Bounded wait on one output; running out ends the run
    task automatic wait_for(input int k, input logic v, input int lim);
        int n;
        n = 0;
        while (pick(k) !== v && n < lim)
        begin
            cyc(1);
            n++;
        end
        chk("wait", {7'h00, v}, {7'h00, pick(k)});
        // Only a value still missing is a timeout
        if (pick(k) !== v)
            final_report();
    endtask
    task automatic send(input logic [7:0] c, input logic [7:0] a);
        req_cmd = 1'h1;
        req_code = c;
        req_arg = a;
        cyc(1);
        req_cmd = 1'h0;
        cyc(3);
    endtask
    task automatic ack();
        req_ack = 1'h1;
        cyc(1);
        req_ack = 1'h0;
        cyc(3);
    endtask
    // Host bus events: bit0 suspend, bit1 resume, bit2 bus reset
    task automatic bus_ev(input logic [2:0] m);
        usb_bus_reset = m[2];
        usb_resume = m[1];
        usb_suspend = m[0];
        cyc(1);
        usb_bus_reset = 1'h0;
        usb_resume = 1'h0;
        usb_suspend = 1'h0;
    endtask
    // Wait until the monitor has used every note, then clear events
    task automatic collect();
        int n;
        n = 0;
        while (ev_q.size() > 0 && n < 300)
        begin
            cyc(1);
            n++;
        end
        chk("notes", 8'h00, 8'(ev_q.size()));
        if (ev_q.size() > 0)
            final_report();
        ack();
    endtask

    // New event word against the oldest note; unnoted words are skipped
    always @(negedge mclk)
    begin
        if (rst_n && prev_ev === EV_NONE && link.event_status !== EV_NONE && ev_q.size() > 0)
            chk("events", ev_q.pop_front(), link.event_status);
        prev_ev <= link.event_status;
    end

    initial
    begin
        // Idle levels; host attached, nothing pending
        mclk = 1'h0;
        rst_n = 1'h0;
        usb_attach = 1'h1;
        usb_suspend = 1'h0;
        usb_resume = 1'h0;
        usb_bus_reset = 1'h0;
        usb_rwake_enable = 1'h0;
        req_cmd = 1'h0;
        req_write = 1'h0;
        req_ack = 1'h0;
        req_code = 8'h00;
        req_arg = 8'h00;
        void'($urandom(25));
        cyc(2);
        rst_n = 1'h1;
        cyc(1);
        chk("ready", 8'h01, {7'h00, link.serial_ready_pin});
        send(CMD_CLASS_RUN, RUN_START);
        ack();
        // Suspend, then a refused write
        ev_q.push_back(8'h01);
        bus_ev(3'h1);
        chk("suspended", 8'h01, {7'h00, usb_suspended});
        t_susp = $time;
        collect();
        ev_q.push_back(8'h08);
        req_write = 1'h1;
        cyc(1);
        req_write = 1'h0;
        collect();
        // Sleep, ignored write, resume wakes via the client
        send(CMD_CLASS_RUN, RUN_STOP);
        ack();
        chk("sleep_delay", 8'h01, {7'h00, (($time - t_susp) < SLEEP_LIMIT_CYC * 20)});
        send(CMD_SLEEP, 8'($urandom));
        wait_for(0, 1'h0, 8);
        chk("sleep", 8'h01, {7'h00, chip_sleep});
        req_write = 1'h1;
        cyc(1);
        req_write = 1'h0;
        cyc(3);
        chk("error", 8'h00, {7'h00, link.error_flag});
        ev_q.push_back(8'h04);
        bus_ev(3'h2);
        wait_for(4, 1'h1, 10);
        wait_for(0, 1'h1, 40);
        collect();
        chk("suspended", 8'h00, {7'h00, usb_suspended});
        // Remote wakeup and report after resume
        usb_rwake_enable = 1'h1;
        send(CMD_CLASS_RUN, RUN_START);
        ack();
        ev_q.push_back(8'h01);
        bus_ev(3'h1);
        collect();
        send(CMD_SEND_REPORT, 8'($urandom));
        wait_for(1, 1'h1, 8);
        ev_q.push_back(8'h04);
        bus_ev(3'h2);
        wait_for(2, 1'h1, 20);
        collect();
        // Bus reset out of suspend reconnects
        ev_q.push_back(8'h01);
        bus_ev(3'h1);
        collect();
        bus_ev(3'h4);
        wait_for(3, 1'h0, 4);
        wait_for(3, 1'h1, 8);
        ack();
        // Detach while asleep; attached, so class run stops first
        send(CMD_CLASS_RUN, RUN_STOP);
        ack();
        send(CMD_SLEEP, 8'h00);
        wait_for(0, 1'h0, 8);
        ev_q.push_back(8'h02);
        usb_attach = 1'h0;
        wait_for(0, 1'h1, 40);
        collect();
        // Unattached sleep at a random run setting
        send(CMD_CLASS_RUN, $urandom_range(1, 0) ? RUN_START : RUN_STOP);
        ack();
        send(CMD_SLEEP, 8'h00);
        wait_for(0, 1'h0, 8);
        final_report();
    end
endmodule
